// ===== core/wwdt_core.sv
// windowed watchdog timer core
`timescale 1ns/1ps

module wwdt_core
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// low-power rc oscillator
	input  wire logic                low_power_rc_osc_clk,
	output logic                     low_power_rc_osc_en,
	// configuration word
	input  wire logic [9:0]          wdog_config_word,
	// core events, one-cycle pulses; power_save_idle is a level read only with power_save_instr
	input  wire logic                clear_wdog_instr,
	input  wire logic                power_save_instr,
	input  wire logic                power_save_idle,
	input  wire logic                wake_event,
	input  wire logic                clk_switch_done,
	// reset control register port
	input  wire logic                rcr_wr,
	input  wire logic [5:0]          rcr_wdata,
	output logic      [5:0]          reset_control_reg,
	// results
	output logic                     wdog_reset_req,
	output logic                     wdog_wake
);

	// -----------------------------------------------------------------
	// configuration decode
	// -----------------------------------------------------------------
	logic       force_en;
	logic       pre_long;
	logic       win_dis;
	logic [3:0] post_sel;
	logic [1:0] win_sel;
	logic       wdog_on;

	assign force_en = wdog_config_word[wwdt_pkg::CFG_FORCE_EN_BIT];
	assign pre_long = wdog_config_word[wwdt_pkg::CFG_PRE_BIT];
	assign win_dis  = wdog_config_word[wwdt_pkg::CFG_WIN_DIS_BIT];
	assign post_sel = wdog_config_word[wwdt_pkg::CFG_POST_LSB +: 4];
	assign win_sel  = wdog_config_word[wwdt_pkg::CFG_WIN_LSB +: 2];

	logic [5:0] rcr_q;
	assign reset_control_reg = rcr_q;
	// forced or soft enable
	assign wdog_on = force_en | rcr_q[wwdt_pkg::RCR_SOFT_EN_BIT];
	assign low_power_rc_osc_en = wdog_on;

	// -----------------------------------------------------------------
	// rc clock synchroniser and edge detect
	// -----------------------------------------------------------------
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic tick;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end
		else
		begin
			s1_q <= low_power_rc_osc_clk;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign tick = wdog_on & s2_q & ~s3_q;

	// -----------------------------------------------------------------
	// power state
	// -----------------------------------------------------------------
	wwdt_pkg::wwdt_pwr_t pwr_q;
	wwdt_pkg::wwdt_pwr_t pwr_d;
	logic                timeout;
	logic                leave_ps;

	assign leave_ps = (pwr_q != wwdt_pkg::WWDT_RUN) & (wake_event | timeout);

	always_comb
	begin
		pwr_d = pwr_q;
		unique case (pwr_q)
			wwdt_pkg::WWDT_RUN:
				if (power_save_instr)
					pwr_d = power_save_idle ? wwdt_pkg::WWDT_IDLE
						: wwdt_pkg::WWDT_SLEEP;
			wwdt_pkg::WWDT_SLEEP,
			wwdt_pkg::WWDT_IDLE:
				if (leave_ps)
					pwr_d = wwdt_pkg::WWDT_RUN;
			default:
				pwr_d = wwdt_pkg::WWDT_RUN;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pwr_q <= wwdt_pkg::WWDT_RUN;
		else
			pwr_q <= pwr_d;
	end

	// -----------------------------------------------------------------
	// clear sources
	// -----------------------------------------------------------------
	logic running;
	logic clr_ok;
	logic early_clr;
	logic clr_all;

	assign running = (pwr_q == wwdt_pkg::WWDT_RUN);
	assign clr_ok  = running & clear_wdog_instr;
	assign clr_all = clk_switch_done
		| (running & power_save_instr)
		| leave_ps
		| clr_ok
		| ~wdog_on;

	// -----------------------------------------------------------------
	// prescaler and postscaler
	// -----------------------------------------------------------------
	logic [6:0]  pre_q;
	logic [14:0] post_q;
	logic [6:0]  pre_max;
	logic [14:0] post_max;
	logic        pre_wrap;
	logic        expire;

	// divide by 128 when set, else by 32
	assign pre_max = pre_long ? 7'h7F : 7'h1F;
	assign pre_wrap = tick & (pre_q == pre_max);
	// ratio 2**sel, top code gives 1:32768
	assign post_max = 15'((16'h0001 << post_sel) - 16'h0001);
	assign timeout = pre_wrap & (post_q == post_max);
	// a clear instruction in the same cycle as the last tick wins
	assign expire = timeout & ~clr_ok;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pre_q  <= wwdt_pkg::PRE_RST;
			post_q <= wwdt_pkg::POST_RST;
		end
		else if (clr_all | timeout)
		begin
			pre_q  <= wwdt_pkg::PRE_RST;
			post_q <= wwdt_pkg::POST_RST;
		end
		else if (tick)
		begin
			pre_q <= pre_wrap ? wwdt_pkg::PRE_RST : 7'(pre_q + 7'h01);
			if (pre_wrap)
				post_q <= 15'(post_q + 15'h0001);
		end
	end

	// -----------------------------------------------------------------
	// window check
	// -----------------------------------------------------------------
	logic [16:0] win_open_at;
	logic [16:0] period;
	logic        in_window;

	assign period = {2'b00, post_max} + 17'h0_0001;
	// window is the last part of the period
	always_comb
	begin
		unique case (win_sel)
			wwdt_pkg::WIN_25: win_open_at = period - (period >> 2);
			wwdt_pkg::WIN_37: win_open_at = period - (period >> 2)
				- (period >> 3);
			wwdt_pkg::WIN_50: win_open_at = period >> 1;
			wwdt_pkg::WIN_75: win_open_at = period >> 2;
		endcase
	end

	assign in_window = ({2'b00, post_q} >= win_open_at)
		| (post_q == post_max);
	assign early_clr = clr_ok & ~win_dis & ~in_window
		& wdog_on;

	// -----------------------------------------------------------------
	// reset request and wake outputs
	// -----------------------------------------------------------------
	logic bite;
	assign bite = (running & expire) | early_clr;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wdog_reset_req <= 1'b0;
			wdog_wake      <= 1'b0;
		end
		else
		begin
			wdog_reset_req <= bite;
			wdog_wake      <= ~running & timeout;
		end
	end

	// -----------------------------------------------------------------
	// reset control register
	// -----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rcr_q <= wwdt_pkg::RCR_RST;
		else
		begin
			if (rcr_wr)
			begin
				rcr_q[wwdt_pkg::RCR_IDLE_BIT] <=
					rcr_wdata[wwdt_pkg::RCR_IDLE_BIT];
				rcr_q[wwdt_pkg::RCR_SLEEP_BIT] <=
					rcr_wdata[wwdt_pkg::RCR_SLEEP_BIT];
				rcr_q[wwdt_pkg::RCR_TIMEOUT_BIT] <=
					rcr_wdata[wwdt_pkg::RCR_TIMEOUT_BIT];
				rcr_q[wwdt_pkg::RCR_SOFT_EN_BIT] <=
					rcr_wdata[wwdt_pkg::RCR_SOFT_EN_BIT];
				rcr_q[1:0] <= rcr_wdata[1:0];
			end
			if (running & power_save_instr)
			begin
				if (power_save_idle)
					rcr_q[wwdt_pkg::RCR_IDLE_BIT] <= 1'b1;
				else
					rcr_q[wwdt_pkg::RCR_SLEEP_BIT] <= 1'b1;
			end
			if (expire | early_clr)
				rcr_q[wwdt_pkg::RCR_TIMEOUT_BIT] <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	sequence s_bite;
		running & expire;
	endsequence

	AST_BITE_RESET: assert property (@(posedge clk) disable iff (rst)
		s_bite |=> wdog_reset_req & rcr_q[wwdt_pkg::RCR_TIMEOUT_BIT])
		else $error("time-out did not request reset");

	AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (rst)
		$past(rcr_q[wwdt_pkg::RCR_TIMEOUT_BIT]) & ~$past(rcr_wr)
		|-> rcr_q[wwdt_pkg::RCR_TIMEOUT_BIT])
		else $error("time-out flag dropped without write");

	AST_FORCE_ON: assert property (@(posedge clk) disable iff (rst)
		force_en |-> low_power_rc_osc_en)
		else $error("forced watchdog not running");

	AST_CLR_INSTR: assert property (@(posedge clk) disable iff (rst)
		clr_ok & ~early_clr |=> pre_q == 7'h00 && post_q == 15'h0000)
		else $error("clear instruction did not clear counts");

	AST_SWITCH_CLR: assert property (@(posedge clk) disable iff (rst)
		clk_switch_done |=> pre_q == 7'h00 && post_q == 15'h0000)
		else $error("clock switch did not clear counts");

	AST_WAKE: assert property (@(posedge clk) disable iff (rst)
		~running & timeout |=> wdog_wake & running)
		else $error("time-out in power save did not wake");

	AST_EARLY: assert property (@(posedge clk) disable iff (rst)
		clr_ok & ~win_dis & ~in_window & wdog_on |=> wdog_reset_req)
		else $error("early clear not punished");

	AST_NOWIN: assert property (@(posedge clk) disable iff (rst)
		win_dis & clr_ok |=> ~wdog_reset_req)
		else $error("clear refused in non-windowed mode");

	AST_PRE_RANGE: assert property (@(posedge clk) disable iff (rst)
		~pre_long |-> pre_q <= 7'h1F)
		else $error("short prescaler overran 32");

endmodule

// ===== core/wwdt_pkg.sv
// constants for the windowed watchdog timer
package wwdt_pkg;

	// -----------------------------------------------------------------
	// configuration word layout
	// -----------------------------------------------------------------
	localparam int CFG_POST_LSB      = 0;
	localparam int CFG_POST_W        = 4;
	localparam int CFG_PRE_BIT       = 4;
	localparam int CFG_WIN_DIS_BIT   = 6;
	localparam int CFG_FORCE_EN_BIT  = 7;
	localparam int CFG_WIN_LSB       = 8;
	localparam int CFG_WIN_W         = 2;
	localparam int CFG_W             = 10;

	// -----------------------------------------------------------------
	// reset control register bit positions
	// -----------------------------------------------------------------
	localparam int RCR_IDLE_BIT      = 2;
	localparam int RCR_SLEEP_BIT     = 3;
	localparam int RCR_TIMEOUT_BIT   = 4;
	localparam int RCR_SOFT_EN_BIT   = 5;
	localparam int RCR_W             = 6;

	// -----------------------------------------------------------------
	// counter sizes and reset values
	// -----------------------------------------------------------------
	localparam int PRE_SHORT_BITS    = 5;
	localparam int PRE_LONG_BITS     = 7;
	localparam int POST_W            = 15;
	localparam logic [6:0]  PRE_RST  = 7'h00;
	localparam logic [14:0] POST_RST = 15'h0000;
	localparam logic [5:0]  RCR_RST  = 6'h00;

	// -----------------------------------------------------------------
	// window select codes
	// -----------------------------------------------------------------
	localparam logic [1:0] WIN_25    = 2'h3;
	localparam logic [1:0] WIN_37    = 2'h2;
	localparam logic [1:0] WIN_50    = 2'h1;
	localparam logic [1:0] WIN_75    = 2'h0;

	// -----------------------------------------------------------------
	// power state of the core
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		WWDT_RUN   = 2'b00,
		WWDT_SLEEP = 2'b01,
		WWDT_IDLE  = 2'b10
	} wwdt_pwr_t;

endpackage

// ===== verification/test_windowed_watchdog_timer.sv
// self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
module test_windowed_watchdog_timer;
	typedef struct {logic wake; int ticks;} wwdt_exp_t;
	logic       clk = 0, rst = 1, clr = 0, psi = 0, idle = 0;
	logic       wk = 0, sw = 0, rwr = 0, rc_osc, osc_en, req, wake;
	logic [5:0] wd = 0, rcr;
	logic [9:0] cfg = 0;
	wwdt_exp_t  q[$];
	wwdt_exp_t  e;
	int         n_errors = 0, n_compared = 0, cyc = 0, t0 = 0;
	int         r, d, s;

	always #4 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	wwdt_rc_osc_model i_wwdt_rc_osc_model (.clk(clk), .rst(rst),
		.osc_en(osc_en), .rc_osc(rc_osc));
	wwdt_core i_wwdt_core (.clk(clk), .rst(rst),
		.low_power_rc_osc_clk(rc_osc),
		.low_power_rc_osc_en(osc_en), .wdog_config_word(cfg),
		.clear_wdog_instr(clr), .power_save_instr(psi),
		.power_save_idle(idle), .wake_event(wk),
		.clk_switch_done(sw), .rcr_wr(rwr), .rcr_wdata(wd),
		.reset_control_reg(rcr), .wdog_reset_req(req),
		.wdog_wake(wake));

	// -------------------------------------------------------------
	// tasks
	// -------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic setup(input logic [9:0] c);
		@(posedge clk);
		rst <= 1'b1;
		cfg <= c;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		t0 = cyc;
	endtask
	task automatic ev(input int k);
		@(posedge clk);
		clr  <= k == 0;
		psi  <= k == 1 || k == 2;
		idle <= k == 2;
		wk   <= k == 3;
		sw   <= k == 4;
		@(posedge clk);
		{clr, psi, wk, sw} <= 4'h0;
		#1;
		t0 = cyc;
	endtask
	task automatic wr(input logic [5:0] v);
		@(posedge clk);
		rwr <= 1'b1;
		wd  <= v;
		@(posedge clk);
		rwr <= 1'b0;
		#1;
		t0 = cyc;
	endtask
	task automatic fin(input string n);
		check(8'(q.size()), 8'h00);
		$display("test %s done", n);
	endtask

	// -------------------------------------------------------------
	// result monitor
	// -------------------------------------------------------------
	always @(posedge clk)
		if (req === 1'b1 || wake === 1'b1)
		begin
			if (q.size() == 0)
				check({6'h0, req, wake}, 8'h00);
			else
			begin
				e = q.pop_front();
				d = cyc - t0 - e.ticks * 8;
				check({6'h0, req, wake}, {6'h0, ~e.wake, e.wake});
				check(8'(d >= -24 && d <= 40), 8'h01);
				if (!e.wake)
					check({7'h0, rcr[4]}, 8'h01);
			end
		end

	initial
	begin
		repeat (40000) @(posedge clk);
		n_errors++;
		report_and_stop();
	end

	// -------------------------------------------------------------
	// tests
	// -------------------------------------------------------------
	initial
	begin
		r = $urandom(32'h5895);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1;
		check({2'h0, rcr}, 8'h00);
		setup(10'h040);
		check({7'h0, osc_en}, 8'h00);
		repeat (400) @(posedge clk);
		r = $urandom % 4;
		wr({4'h8, r[1:0]});
		check({7'h0, osc_en}, 8'h01);
		q.push_back('{1'b0, 32});
		repeat (300) @(posedge clk);
		check({2'h0, rcr}, {4'hC, r[1:0]});
		wr(6'h00);
		check({2'h0, rcr}, 8'h00);
		repeat (400) @(posedge clk);
		fin("soft_enable");
		setup(10'h0c0);
		wr(6'h20);
		wr(6'h00);
		check({7'h0, osc_en}, 8'h01);
		q.push_back('{1'b0, 32});
		repeat (280) @(posedge clk);
		fin("force_enable");
		setup(10'h0d0);
		q.push_back('{1'b0, 128});
		repeat (1060) @(posedge clk);
		fin("prescale_128");
		setup(10'h0c0);
		for (int i = 0; i < 8; i++)
		begin
			repeat (40 + $urandom % 150) @(posedge clk);
			ev(i % 2 ? 0 : 4);
		end
		q.push_back('{1'b0, 32});
		repeat (290) @(posedge clk);
		fin("clear_and_switch");
		for (int k = 1; k < 3; k++)
		begin
			setup(10'h0c0);
			ev(k);
			check({2'h0, rcr}, k == 1 ? 8'h08 : 8'h04);
			q.push_back('{1'b1, 32});
			repeat (290) @(posedge clk);
			check({2'h0, rcr}, k == 1 ? 8'h18 : 8'h14);
			wr(6'h00);
			check({2'h0, rcr}, 8'h00);
			fin("sleep_idle_wake");
		end
		setup(10'h0c0);
		ev(1);
		repeat (100) @(posedge clk);
		ev(3);
		q.push_back('{1'b0, 32});
		repeat (290) @(posedge clk);
		fin("wake_restart");
		for (int w = 0; w < 4; w++)
			for (int early = 1; early >= 0; early--)
			begin
				s = (w == 0) ? 6 : (w == 1) ? 4 : (w == 2) ? 3 : 2;
				setup({w[1:0], 8'h83});
				check({2'h0, rcr}, 8'h00);
				repeat (((8 - s) * 32 + (early ? -16 : 16)) * 8)
					@(posedge clk);
				ev(0);
				if (early)
					q.push_back('{1'b0, 0});
				repeat (30) @(posedge clk);
				fin("window");
			end
		report_and_stop();
	end
endmodule

// ===== verification/wwdt_low_power_rc_osc_model.sv
// low-power rc oscillator model for the watchdog bench
`timescale 1ns/1ps
module wwdt_rc_osc_model
#(
	parameter int HALF = 4
)
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// oscillator
	input  wire logic osc_en,
	output logic      rc_osc
);
	int cnt;
	// toggles only while enabled, else stands still
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			cnt  <= 0;
			rc_osc <= 1'b0;
		end
		else if (osc_en)
		begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				rc_osc <= ~rc_osc;
		end
endmodule
